/* inc/iorsd_pkg.sv */
// Package: address map, fields and constants of the I/O register space decoder
package iorsd_pkg;
	// ==========================================================
	// Address spaces
	localparam logic [5:0] IO_BIT_LAST = 6'h1f; // Last bit-accessible I/O number
	localparam logic [5:0] IO_PORT_LAST = 6'h3f; // Last I/O-port number
	localparam logic [7:0] IO_DATA_OFFSET = 8'h20; // Data address of I/O number 0
	localparam logic [7:0] EXT_FIRST = 8'h60; // First extended I/O address
	localparam logic [7:0] EXT_LAST = 8'hff; // Last extended I/O address
	// ==========================================================
	// Low-space registers modelled here (data addresses)
	localparam logic [7:0] ADDR_SELF_PROGRAM_CONTROL = 8'h57;
	localparam logic [7:0] ADDR_STACK_POINTER_HIGH = 8'h5e;
	localparam logic [7:0] ADDR_EEPROM_ADDR_HIGH = 8'h42;
	localparam logic [7:0] ADDR_TIMER_A8_FLAGS = 8'h35;
	localparam logic [7:0] ADDR_TIMER_B16_FLAGS = 8'h36;
	localparam logic [7:0] ADDR_TIMER_C8_FLAGS = 8'h37;
	localparam logic [7:0] ADDR_GP_IO_0 = 8'h3e;
	// Field positions
	localparam int SP_BIT10_POS = 2;
	localparam int FLASH_BUSY_POS = 6;
	localparam int FLASH_REEN_POS = 4;
	localparam logic [7:0] SP_HIGH_MASK_LARGE = 8'h07;
	localparam logic [7:0] SP_HIGH_MASK_SMALL = 8'h03;
	localparam logic [7:0] SPM_MASK_SMALL = 8'haf;
	localparam logic [7:0] EEAR_HIGH_MASK = 8'h01;
	localparam logic [7:0] TIMER_A8_FLAG_MASK = 8'h07;
	localparam logic [7:0] TIMER_B16_FLAG_MASK = 8'h27;
	// ==========================================================
	// Extended-space registers
	localparam int EXT_COUNT = 44;
	localparam logic [7:0] EXT_ADDR [EXT_COUNT] = '{
		8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70,
		8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h7f, 8'h80,
		8'h81, 8'h82, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89,
		8'h8a, 8'h8b, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb6,
		8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hc0, 8'hc1,
		8'hc2, 8'hc4, 8'hc5, 8'hc6};
	// Bits software may write (implemented bits)
	localparam logic [7:0] EXT_WMASK [EXT_COUNT] = '{
		8'h07, 8'h0f, 8'hff, 8'h7f, 8'hff, 8'h07, 8'h27, 8'h07,
		8'h00, 8'h00, 8'hff, 8'h47, 8'hef, 8'hff, 8'h03, 8'hf3,
		8'hdf, 8'hc0, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hf3, 8'hcf, 8'hff, 8'hff, 8'hff, 8'h60,
		8'hff, 8'h03, 8'hff, 8'hff, 8'hf5, 8'hfe, 8'h03, 8'hff,
		8'hff, 8'hff, 8'h0f, 8'hff};
	// Write-only register reads zero
	localparam int EXT_WO_INDEX = 17;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Access kinds issued by the core
	typedef enum logic [2:0] {
		IORSD_NONE, IORSD_MEM_READ, IORSD_MEM_WRITE, IORSD_PORT_READ, IORSD_PORT_WRITE,
		IORSD_SET_BIT, IORSD_CLEAR_BIT, IORSD_TEST_BIT
	} iorsd_op_t;
endpackage

/* logic/iorsd_decoder.sv */
// Decoder and access rules for the I/O and extended I/O register space
// Summary of operation
// - Bit set/clear only on I/O 0x00-0x1F
// - Bit test and skip on low range
// - Writing one clears status flags
// - Bit set/clear touches only addressed bit
// - Port accesses use I/O numbers 0x00-0x3F
// - Data address equals I/O number plus 0x20
// - Extended range only by load/store
// - Large-variant bits absent on small variant
`timescale 1ns/1ps
`default_nettype none
module iorsd_decoder #(
	parameter bit LARGE_VARIANT = 1'b1 // Larger-memory variant present
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Core access
	input wire iorsd_pkg::iorsd_op_t op,
	input wire logic [7:0] addr,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic skip,
	output logic valid,
	// Peripheral status inputs
	input wire logic [2:0] timer_flag_set,
	input wire logic flash_busy_in,
	input wire logic [9:0] conv_result_in,
	// Register outputs
	output logic [7:0] stack_pointer_high,
	output logic [7:0] eeprom_addr_high,
	output logic flash_section_reenable,
	output logic [7:0] ext_reg_out [iorsd_pkg::EXT_COUNT]
);
	// ==========================================================
	// Reset synchroniser
	logic rst_meta_reg, rst_n_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end
	// ==========================================================
	// Address decode
	logic [7:0] daddr; // Unified data-space address
	logic is_port, is_bitop, is_write, is_read;
	logic [7:0] tf_regs [3]; // Timer flag registers
	logic [7:0] gp0_reg; // General purpose scratch
	logic [7:0] sph_reg, eear_reg, spm_reg;
	logic [7:0] ext_regs [iorsd_pkg::EXT_COUNT];
	logic bit_ok; // Bit op in low range
	logic [7:0] cur; // Current value at address
	logic hit; // Address is mapped
	logic [7:0] bit_mask;
	always_comb begin
		is_port = (op == iorsd_pkg::IORSD_PORT_READ) || (op == iorsd_pkg::IORSD_PORT_WRITE) ||
			(op == iorsd_pkg::IORSD_SET_BIT) || (op == iorsd_pkg::IORSD_CLEAR_BIT) ||
			(op == iorsd_pkg::IORSD_TEST_BIT);
		// Port numbers are six bits, mapped up by the fixed offset
		daddr = is_port ? ({2'b00, addr[5:0]} + iorsd_pkg::IO_DATA_OFFSET) : addr;
		is_bitop = (op == iorsd_pkg::IORSD_SET_BIT) || (op == iorsd_pkg::IORSD_CLEAR_BIT) ||
			(op == iorsd_pkg::IORSD_TEST_BIT);
		bit_ok = is_bitop && (addr[5:0] <= iorsd_pkg::IO_BIT_LAST);
		is_write = (op == iorsd_pkg::IORSD_MEM_WRITE) || (op == iorsd_pkg::IORSD_PORT_WRITE);
		is_read = (op == iorsd_pkg::IORSD_MEM_READ) || (op == iorsd_pkg::IORSD_PORT_READ);
		bit_mask = 8'h01 << bit_sel;
	end
	// Read mux; unmapped addresses give zero
	always_comb begin
		cur = 8'h00;
		hit = 1'b0;
		unique case (daddr)
			iorsd_pkg::ADDR_TIMER_A8_FLAGS: begin
				cur = tf_regs[0];
				hit = 1'b1;
			end
			iorsd_pkg::ADDR_TIMER_B16_FLAGS: begin
				cur = tf_regs[1];
				hit = 1'b1;
			end
			iorsd_pkg::ADDR_TIMER_C8_FLAGS: begin
				cur = tf_regs[2];
				hit = 1'b1;
			end
			iorsd_pkg::ADDR_GP_IO_0: begin
				cur = gp0_reg;
				hit = 1'b1;
			end
			iorsd_pkg::ADDR_EEPROM_ADDR_HIGH: begin
				// Absent on the small variant
				cur = LARGE_VARIANT ? eear_reg : 8'h00;
				hit = LARGE_VARIANT;
			end
			iorsd_pkg::ADDR_SELF_PROGRAM_CONTROL: begin
				cur = LARGE_VARIANT ? spm_reg : (spm_reg & iorsd_pkg::SPM_MASK_SMALL);
				hit = 1'b1;
			end
			iorsd_pkg::ADDR_STACK_POINTER_HIGH: begin
				cur = sph_reg;
				hit = 1'b1;
			end
			default: begin
				// Extended registers only from load/store
				if (!is_port) begin
					for (int i = 0; i < iorsd_pkg::EXT_COUNT; i++) begin
						if (daddr == iorsd_pkg::EXT_ADDR[i]) begin
							hit = 1'b1;
							cur = (i == iorsd_pkg::EXT_WO_INDEX) ? 8'h00 : ext_regs[i];
							if (i == 8) cur = conv_result_in[7:0];
							if (i == 9) cur = {6'h00, conv_result_in[9:8]};
						end
					end
				end
			end
		endcase
	end
	// ==========================================================
	// Write strobe and effective data; bit ops write only one bit
	logic wr_en;
	logic [7:0] wr_val; // Value for plain registers
	logic [7:0] w1c; // Ones to clear in flag registers
	always_comb begin
		wr_en = hit && (is_write || (bit_ok && op != iorsd_pkg::IORSD_TEST_BIT));
		wr_val = wdata;
		w1c = wdata;
		if (op == iorsd_pkg::IORSD_SET_BIT) begin
			wr_val = cur | bit_mask;
			w1c = bit_mask;
		end else if (op == iorsd_pkg::IORSD_CLEAR_BIT) begin
			wr_val = cur & ~bit_mask;
			w1c = 8'h00;
		end
	end
	// ==========================================================
	// Timer flags: hardware set wins over software clear
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int k = 0; k < 3; k++) tf_regs[k] <= iorsd_pkg::RESET_VALUE;
		end else begin
			for (int k = 0; k < 3; k++) begin
				logic [7:0] clr;
				logic [7:0] fmask;
				clr = (wr_en && daddr == iorsd_pkg::ADDR_TIMER_A8_FLAGS + 8'(k)) ? w1c : 8'h00;
				fmask = (k == 1) ? iorsd_pkg::TIMER_B16_FLAG_MASK : iorsd_pkg::TIMER_A8_FLAG_MASK;
				tf_regs[k] <= ((tf_regs[k] & ~clr) | ({7'h00, timer_flag_set[k]})) & fmask;
			end
		end
	end
	// ==========================================================
	// Low-space plain registers, written on the access edge
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			gp0_reg <= iorsd_pkg::RESET_VALUE;
			sph_reg <= iorsd_pkg::RESET_VALUE;
			eear_reg <= iorsd_pkg::RESET_VALUE;
		end else if (wr_en) begin
			if (daddr == iorsd_pkg::ADDR_GP_IO_0) gp0_reg <= wr_val;
			// Bit 10 of the stack pointer only on the large variant
			if (daddr == iorsd_pkg::ADDR_STACK_POINTER_HIGH) sph_reg <= wr_val &
				(LARGE_VARIANT ? iorsd_pkg::SP_HIGH_MASK_LARGE : iorsd_pkg::SP_HIGH_MASK_SMALL);
			if (daddr == iorsd_pkg::ADDR_EEPROM_ADDR_HIGH) eear_reg <= wr_val &
				iorsd_pkg::EEAR_HIGH_MASK;
		end
	end
	// Self-programming control: busy mirrors flash, re-enable is writable
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			spm_reg <= iorsd_pkg::RESET_VALUE;
		end else begin
			spm_reg[iorsd_pkg::FLASH_BUSY_POS] <= LARGE_VARIANT & flash_busy_in;
			if (wr_en && daddr == iorsd_pkg::ADDR_SELF_PROGRAM_CONTROL) begin
				spm_reg[iorsd_pkg::FLASH_REEN_POS] <= LARGE_VARIANT &
					wr_val[iorsd_pkg::FLASH_REEN_POS];
			end
		end
	end
	// ==========================================================
	// Extended registers: store writable bits only
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int i = 0; i < iorsd_pkg::EXT_COUNT; i++) ext_regs[i] <= iorsd_pkg::RESET_VALUE;
		end else begin
			for (int i = 0; i < iorsd_pkg::EXT_COUNT; i++) begin
				if (wr_en && !is_port && daddr == iorsd_pkg::EXT_ADDR[i]) begin
					ext_regs[i] <= wr_val & iorsd_pkg::EXT_WMASK[i];
				end
			end
		end
	end
	// ==========================================================
	// Answer registered with the access edge, valid one cycle later
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rdata <= 8'h00;
			skip <= 1'b0;
			valid <= 1'b0;
		end else begin
			rdata <= is_read ? cur : 8'h00;
			// Test-and-skip only in the low range
			skip <= bit_ok && hit && (op == iorsd_pkg::IORSD_TEST_BIT) && cur[bit_sel] &&
				wdata[0];
			valid <= (op != iorsd_pkg::IORSD_NONE);
		end
	end
	assign stack_pointer_high = sph_reg;
	assign eeprom_addr_high = eear_reg;
	assign flash_section_reenable = spm_reg[iorsd_pkg::FLASH_REEN_POS];
	assign ext_reg_out = ext_regs;
endmodule
`default_nettype wire

/* testbench/iorsd_decoder_properties.sv */
// Checker: answer timing and decode relations at the decoder ports
`timescale 1ns/1ps
`default_nettype none
module iorsd_decoder_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Core side
	input wire iorsd_pkg::iorsd_op_t op,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic skip,
	input wire logic valid,
	// Extended registers
	input wire logic [7:0] ext_reg_out [iorsd_pkg::EXT_COUNT]
);
	// ==========================================================
	// Access kind decode, kept short for the properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic idle_op = op == iorsd_pkg::IORSD_NONE;
	wire logic mw_op = op == iorsd_pkg::IORSD_MEM_WRITE;
	wire logic tst_op = op == iorsd_pkg::IORSD_TEST_BIT;
	// ==========================================================
	// Properties
	a_valid_after_op: assert property (!idle_op |=> valid)
		else $error("no answer one cycle after access");
	a_idle_silent: assert property (idle_op |=> !valid && !skip)
		else $error("answer without access");
	a_write_rdata_zero: assert property (mw_op |=> rdata == 8'h00)
		else $error("read data after a write");
	a_skip_needs_arm: assert property (tst_op && !wdata[0] |=> !skip)
		else $error("skip while not armed");
	a_test_low_only: assert property (tst_op && addr[5:0] > 6'h1f |=> !skip)
		else $error("skip from a high I/O number");
	a_unused_reads_zero: assert property (op == iorsd_pkg::IORSD_MEM_READ && addr == 8'h67
		|=> rdata == 8'h00)
		else $error("unused address read nonzero");
	a_ext_write_mask: assert property (mw_op && addr == 8'h68
		|=> ext_reg_out[0] == ($past(wdata) & 8'h07))
		else $error("extended write not taken as masked");
	a_port_skips_ext: assert property (op == iorsd_pkg::IORSD_PORT_WRITE
		|=> $stable(ext_reg_out[0]))
		else $error("port write reached extended space");
	// Main scenarios seen
	c_skip: cover property (skip);
	c_ext_write: cover property (mw_op && addr == 8'h68);
	c_port_read: cover property (op == iorsd_pkg::IORSD_PORT_READ ##1 valid);
endmodule
bind iorsd_decoder iorsd_decoder_properties props_i (.clk(clk), .nrst(nrst), .op(op),
	.addr(addr), .wdata(wdata), .rdata(rdata), .skip(skip), .valid(valid),
	.ext_reg_out(ext_reg_out));
`default_nettype wire

/* testbench/iorsd_core_model.sv */
// Core model: issues one access a cycle and collects the answers
`timescale 1ns/1ps
`default_nettype none
module iorsd_core_model (
	// Clock
	input wire logic clk,
	// Requests
	output var iorsd_pkg::iorsd_op_t op,
	output logic [7:0] addr,
	output logic [2:0] bit_sel,
	output logic [7:0] wdata,
	// Answers
	input wire logic [7:0] rdata,
	input wire logic skip,
	input wire logic valid
);
	// ==========================================================
	// Idle at time zero
	initial begin
		op = iorsd_pkg::IORSD_NONE;
		addr = 8'h00;
		bit_sel = 3'h0;
		wdata = 8'h5a;
	end
	// Launched 1 ns after an edge; held until the taking edge, answer read after it
	task automatic acc(input iorsd_pkg::iorsd_op_t o, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d, output logic [7:0] r, output logic s,
		output logic v);
		op = o;
		addr = a;
		bit_sel = b;
		wdata = d;
		@(posedge clk);
		#1;
		r = rdata;
		s = skip;
		v = valid;
	endtask
	// Idle cycle; data lines toggle so stale values never look valid
	task automatic idle();
		op = iorsd_pkg::IORSD_NONE;
		wdata = ~wdata;
		@(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

/* testbench/tb_io_register_space_decode.sv */
// Testbench: directed access sequences against the decoder
`timescale 1ns/1ps
`default_nettype none
module tb_io_register_space_decode;
	// ==========================================================
	// Signals and counters
	logic clk, nrst, flash_busy_in, skip, valid, flash_section_reenable, sv, vv;
	logic [2:0] timer_flag_set, bit_sel;
	logic [9:0] conv_result_in;
	iorsd_pkg::iorsd_op_t op;
	logic [7:0] addr, wdata, rdata, stack_pointer_high, eeprom_addr_high, rv;
	logic [7:0] ext_reg_out [iorsd_pkg::EXT_COUNT];
	int n_fail = 0;
	int checks = 0;
	iorsd_decoder #(.LARGE_VARIANT(1'b1)) iorsd_decoder_i (.clk(clk), .nrst(nrst), .op(op),
		.addr(addr), .bit_sel(bit_sel), .wdata(wdata), .rdata(rdata), .skip(skip),
		.valid(valid), .timer_flag_set(timer_flag_set), .flash_busy_in(flash_busy_in),
		.conv_result_in(conv_result_in), .stack_pointer_high(stack_pointer_high),
		.eeprom_addr_high(eeprom_addr_high), .flash_section_reenable(flash_section_reenable),
		.ext_reg_out(ext_reg_out));
	iorsd_core_model iorsd_core_model_i (.clk(clk), .op(op), .addr(addr), .bit_sel(bit_sel),
		.wdata(wdata), .rdata(rdata), .skip(skip), .valid(valid));
	// ==========================================================
	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// Access; the answer must stand one cycle later
	task automatic a(input iorsd_pkg::iorsd_op_t o, input logic [7:0] ad, input logic [2:0] b,
		input logic [7:0] d);
		iorsd_core_model_i.acc(o, ad, b, d, rv, sv, vv);
		chk({7'h00, vv}, 8'h01);
	endtask
	task automatic w(input logic [7:0] ad, input logic [7:0] d);
		a(iorsd_pkg::IORSD_MEM_WRITE, ad, 3'h0, d);
	endtask
	task automatic r(input logic [7:0] ad, input logic [7:0] exp);
		a(iorsd_pkg::IORSD_MEM_READ, ad, 3'h0, 8'h00);
		chk(rv, exp);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog: tests need about 75 cycles, limit is over thirty times that
	initial begin
		#20000;
		n_fail++;
		summarize();
	end
	// ==========================================================
	// Tests
	initial begin
		nrst = 1'b0;
		timer_flag_set = 3'h0;
		flash_busy_in = 1'b1;
		conv_result_in = 10'h2c5;
		repeat (20) @(posedge clk);
		#1;
		nrst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(ext_reg_out[0], 8'h00);
		// Software keeps unused bits at zero, so only implemented bits are written
		for (int i = 0; i < 8; i++) begin
			w(iorsd_pkg::EXT_ADDR[i], iorsd_pkg::EXT_WMASK[i]);
			r(iorsd_pkg::EXT_ADDR[i], iorsd_pkg::EXT_WMASK[i]);
		end
		w(8'h82, 8'hc0);
		r(8'h82, 8'h00);
		chk(ext_reg_out[17], 8'hc0);
		r(8'h78, 8'hc5);
		r(8'h79, 8'h02);
		$display("extended space done");
		a(iorsd_pkg::IORSD_PORT_WRITE, 8'h1e, 3'h0, 8'ha5);
		r(8'h3e, 8'ha5);
		a(iorsd_pkg::IORSD_PORT_WRITE, 8'h68, 3'h0, 8'h00);
		chk(ext_reg_out[0], 8'h07);
		$display("port path done");
		a(iorsd_pkg::IORSD_SET_BIT, 8'h1e, 3'h1, 8'h00);
		a(iorsd_pkg::IORSD_CLEAR_BIT, 8'h1e, 3'h0, 8'h00);
		a(iorsd_pkg::IORSD_PORT_READ, 8'h1e, 3'h0, 8'h00);
		chk(rv, 8'ha6);
		a(iorsd_pkg::IORSD_SET_BIT, 8'h22, 3'h0, 8'h00);
		chk(eeprom_addr_high, 8'h00);
		for (int k = 0; k < 4; k++) begin
			a(iorsd_pkg::IORSD_TEST_BIT, 8'h1e, {2'b00, k[0]}, {7'h00, k[1]});
			chk({7'h00, sv}, {7'h00, k == 3});
		end
		$display("bit operations done");
		timer_flag_set = 3'h3;
		iorsd_core_model_i.idle();
		timer_flag_set = 3'h0;
		w(8'h35, 8'h00);
		r(8'h35, 8'h01);
		a(iorsd_pkg::IORSD_CLEAR_BIT, 8'h16, 3'h1, 8'h00);
		r(8'h36, 8'h01);
		a(iorsd_pkg::IORSD_SET_BIT, 8'h16, 3'h0, 8'h00);
		r(8'h36, 8'h00);
		w(8'h35, 8'h01);
		r(8'h35, 8'h00);
		$display("status flags done");
		// Reserved addresses are only read; the write goes to a real but unmodelled register
		w(8'h5f, 8'hff);
		r(8'h5f, 8'h00);
		r(8'h67, 8'h00);
		r(8'h71, 8'h00);
		w(iorsd_pkg::ADDR_STACK_POINTER_HIGH, 8'h07);
		chk(stack_pointer_high, 8'h07);
		w(iorsd_pkg::ADDR_EEPROM_ADDR_HIGH, 8'h01);
		chk(eeprom_addr_high, 8'h01);
		r(iorsd_pkg::ADDR_SELF_PROGRAM_CONTROL, 8'h40);
		w(iorsd_pkg::ADDR_SELF_PROGRAM_CONTROL, 8'h10);
		chk({7'h00, flash_section_reenable}, 8'h01);
		r(iorsd_pkg::ADDR_SELF_PROGRAM_CONTROL, 8'h50);
		a(iorsd_pkg::IORSD_TEST_BIT, 8'h3e, 3'h0, 8'h01);
		chk({7'h00, sv}, 8'h00);
		$display("unused and variant done");
		iorsd_core_model_i.idle();
		summarize();
	end
endmodule
`default_nettype wire
